/* hw/anpd_map.svh */
// anpd_map.svh: offsets, bit positions and reset values of the arbitration block
// assumes: included by the design file over an AXI4-Lite register slave
`ifndef ANPD_MAP_SVH
`define ANPD_MAP_SVH
// register byte addresses (mgmt register number times four)
`define ANPD_CTRL_ADDR 8'h00
`define ANPD_STAT_ADDR 8'h04
`define ANPD_ADV_ADDR 8'h10
`define ANPD_LPA_ADDR 8'h14
`define ANPD_EXP_ADDR 8'h18
`define ANPD_QPS_ADDR 8'h44
`define ANPD_LINK_ADDR 8'h80
// control bits
`define ANPD_CTRL_RESTART 9
`define ANPD_CTRL_ENABLE 12
// status bits
`define ANPD_STAT_DONE 5
// expansion bits
`define ANPD_EXP_LPNEG 0
`define ANPD_EXP_PDF 4
// summary status bits
`define ANPD_QPS_DONE 4
`define ANPD_QPS_NOSIG 3
// ability bits in the advertisement and partner words
`define ANPD_AB_10H 5
`define ANPD_AB_10F 6
`define ANPD_AB_TXH 7
`define ANPD_AB_TXF 8
`define ANPD_AB_T4 9
// reset values
`define ANPD_ADV_RST 16'h01E1
`define ANPD_CTRL_RST 16'h1000
// bus answer codes
`define ANPD_RESP_OKAY 2'h0
`define ANPD_RESP_SLVERR 2'h2
`endif

/* hw/anpd_pkg.sv */
// anpd_pkg.sv: types shared by the arbitration block
// assumes: constants come from anpd_map.svh
package anpd_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SEND = 5'h02,
    ST_ARB = 5'h04,
    ST_DONE = 5'h08,
    ST_FAULT = 5'h10
  } anpd_state_t;
  // one-hot technology enables
  typedef struct packed {
    logic txFull;
    logic txHalf;
    logic tenFull;
    logic tenHalf;
  } anpd_tech_t;
  // what the receive channel currently shows
  typedef struct packed {
    logic flpSeen;
    logic nlpSeen;
    logic idleSeen;
    logic wordValid;
    logic [15:0] word;
  } anpd_rx_t;
endpackage

/* hw/anpd_arbiter.sv */
// anpd_arbiter.sv: auto-negotiation arbitration with parallel detection
// assumes: AXI4-Lite master on mclk; line indications come from other clocks
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "anpd_map.svh"
module anpd_arbiter #(
  parameter int WAIT_CYCLES = 4096
) (
  input wire logic mclk,
  input wire logic nrst,
  // line side indications from the receive front end
  input wire logic flpRx,
  input wire logic nlpRx,
  input wire logic idleRx,
  input wire logic wordStb,
  input wire logic [15:0] wordRx,
  // line side outputs
  output logic sendFlp,
  output logic [15:0] flpWord,
  output anpd_pkg::anpd_tech_t techEn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  anpd_pkg::anpd_state_t state_ff;
  logic [3:0][2:0] syncQ_ff;
  logic [3:0] lineIn, lineLvl_ff;
  logic flpLvl_ff, nlpLvl_ff, idleLvl_ff, stbLvl_ff, stbOld_ff;
  logic [15:0] ctrl_ff, adv_ff, lpa_ff;
  logic lpNeg_ff, pdFault_ff, done_ff, noSig_ff, enOld_ff;
  logic [31:0] wait_ff;
  logic [7:0] awAddr_ff;
  logic awHave_ff, wHave_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic restartReq;
  logic stbRise;
  logic [1:0] indCount;
  anpd_pkg::anpd_tech_t pick;
  ////////////////////////////////////////////////////////////////////////////
  // line input synchronisers: change counts when stages two and three agree
  assign lineIn = {wordStb, idleRx, nlpRx, flpRx};
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncQ_ff <= '0;
      lineLvl_ff <= 4'h0;
      stbOld_ff <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        syncQ_ff[k] <= {syncQ_ff[k][1:0], lineIn[k]};
        if (syncQ_ff[k][1] == syncQ_ff[k][2])
          lineLvl_ff[k] <= syncQ_ff[k][2];
      end
      stbOld_ff <= lineLvl_ff[3];
    end
  end
  assign {stbLvl_ff, idleLvl_ff, nlpLvl_ff, flpLvl_ff} = lineLvl_ff;
  // word is held stable by the front end while its strobe is high
  assign stbRise = stbLvl_ff && !stbOld_ff;
  assign indCount = 2'(flpLvl_ff) + 2'(nlpLvl_ff) + 2'(idleLvl_ff);
  ////////////////////////////////////////////////////////////////////////////
  // priority resolution, used for negotiated words and for parallel detection
  function automatic anpd_pkg::anpd_tech_t resolve(input logic [15:0] a, input logic [15:0] b);
    anpd_pkg::anpd_tech_t t;
    logic [15:0] c;
    t = '0;
    c = a & b;
    if (c[`ANPD_AB_TXF])
      t.txFull = 1'b1;
    else if (c[`ANPD_AB_TXH])
      t.txHalf = 1'b1;
    else if (c[`ANPD_AB_10F])
      t.tenFull = 1'b1;
    else if (c[`ANPD_AB_10H])
      t.tenHalf = 1'b1;
    return t;
  endfunction
  // T4 is never enabled locally, so it drops out of the common set
  assign pick = resolve(adv_ff & ~(16'h0001 << `ANPD_AB_T4), lpa_ff);
  ////////////////////////////////////////////////////////////////////////////
  // restart sources
  // restart bit, or the enable bit going from clear to set
  assign restartReq = ctrl_ff[`ANPD_CTRL_RESTART] || (ctrl_ff[`ANPD_CTRL_ENABLE] && !enOld_ff);
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      enOld_ff <= 1'b1;
    else
      enOld_ff <= ctrl_ff[`ANPD_CTRL_ENABLE];
  end
  ////////////////////////////////////////////////////////////////////////////
  // arbitration state machine
  // reset to idle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= anpd_pkg::ST_IDLE;
      wait_ff <= 32'h0;
    end
    else if (!ctrl_ff[`ANPD_CTRL_ENABLE] || restartReq)
    begin
      state_ff <= anpd_pkg::ST_IDLE;
      wait_ff <= 32'h0;
    end
    else
    begin
      case (state_ff)
        anpd_pkg::ST_IDLE:
        begin
          state_ff <= anpd_pkg::ST_SEND;
          wait_ff <= 32'h0;
        end
        anpd_pkg::ST_SEND:
        begin
          if (indCount > 2'h1)
            state_ff <= anpd_pkg::ST_FAULT;
          else if (stbRise && flpLvl_ff)
            state_ff <= anpd_pkg::ST_ARB;
          else if ((nlpLvl_ff || idleLvl_ff) && wait_ff >= 32'(WAIT_CYCLES))
            state_ff <= anpd_pkg::ST_DONE;
          else if (wait_ff < 32'(WAIT_CYCLES))
            wait_ff <= wait_ff + 32'h1;
        end
        anpd_pkg::ST_ARB:
          state_ff <= anpd_pkg::ST_DONE;
        anpd_pkg::ST_DONE:
          state_ff <= anpd_pkg::ST_DONE;
        anpd_pkg::ST_FAULT:
          // stays faulted until restart, enable clear or a clean line; a clean line retries from idle
          if (indCount == 2'h0)
            state_ff <= anpd_pkg::ST_IDLE;
        default:
          state_ff <= anpd_pkg::ST_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // partner ability, negotiation and detection status
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      lpa_ff <= 16'h0;
      lpNeg_ff <= 1'b0;
      pdFault_ff <= 1'b0;
      done_ff <= 1'b0;
      noSig_ff <= 1'b0;
    end
    else
    begin
      noSig_ff <= (indCount == 2'h0);
      if (restartReq)
        done_ff <= 1'b0;
      if (state_ff == anpd_pkg::ST_SEND)
      begin
        if (stbRise && flpLvl_ff && indCount == 2'h1)
        begin
          lpa_ff <= wordRx;
          lpNeg_ff <= 1'b1;
        end
        else if (indCount == 2'h1 && wait_ff >= 32'(WAIT_CYCLES))
        begin
          lpNeg_ff <= 1'b0;
          lpa_ff <= 16'h0;
          lpa_ff[`ANPD_AB_10H] <= nlpLvl_ff;
          lpa_ff[`ANPD_AB_TXH] <= idleLvl_ff;
          done_ff <= nlpLvl_ff || idleLvl_ff;
        end
        if (indCount > 2'h1)
          pdFault_ff <= 1'b1;
      end
      if (state_ff == anpd_pkg::ST_ARB)
        done_ff <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // line outputs
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sendFlp <= 1'b0;
      flpWord <= 16'h0;
      techEn <= '0;
    end
    else
    begin
      sendFlp <= (state_ff == anpd_pkg::ST_SEND);
      flpWord <= adv_ff;
      if (state_ff == anpd_pkg::ST_DONE && done_ff)
        techEn <= lpNeg_ff ? pick : resolve(16'hFFFF, lpa_ff);
      else
        techEn <= '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data in either order
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= 8'h0;
      wData_ff <= 32'h0;
      wStrb_ff <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `ANPD_RESP_OKAY;
    end
    else
    begin
      awready <= !awHave_ff && !awready && !bvalid;
      wready <= !wHave_ff && !wready && !bvalid;
      if (awvalid && awready)
      begin
        awHave_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHave_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end
      if (awHave_ff && wHave_ff && !bvalid)
      begin
        bvalid <= 1'b1;
        bresp <= (awAddr_ff == `ANPD_CTRL_ADDR || awAddr_ff == `ANPD_ADV_ADDR ||
                  awAddr_ff == `ANPD_STAT_ADDR || awAddr_ff == `ANPD_LPA_ADDR ||
                  awAddr_ff == `ANPD_EXP_ADDR || awAddr_ff == `ANPD_QPS_ADDR) ?
                 `ANPD_RESP_OKAY : `ANPD_RESP_SLVERR;
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end
  // writable registers, low two byte lanes only
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_ff <= `ANPD_CTRL_RST;
      adv_ff <= `ANPD_ADV_RST;
    end
    else
    begin
      if (ctrl_ff[`ANPD_CTRL_RESTART])
        ctrl_ff[`ANPD_CTRL_RESTART] <= 1'b0;
      if (awHave_ff && wHave_ff && !bvalid)
      begin
        for (int i = 0; i < 2; i++)
        begin
          if (wStrb_ff[i] && awAddr_ff == `ANPD_CTRL_ADDR)
            ctrl_ff[i*8 +: 8] <= wData_ff[i*8 +: 8];
          if (wStrb_ff[i] && awAddr_ff == `ANPD_ADV_ADDR)
            adv_ff[i*8 +: 8] <= wData_ff[i*8 +: 8];
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, one cycle after address is taken
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `ANPD_RESP_OKAY;
    end
    else
    begin
      arready <= !arready && !rvalid;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp <= `ANPD_RESP_OKAY;
        rdata <= 32'h0;
        case (araddr)
          `ANPD_CTRL_ADDR: rdata[15:0] <= ctrl_ff;
          `ANPD_STAT_ADDR: rdata[`ANPD_STAT_DONE] <= done_ff;
          `ANPD_ADV_ADDR: rdata[15:0] <= adv_ff;
          `ANPD_LPA_ADDR: rdata[15:0] <= lpa_ff;
          `ANPD_EXP_ADDR:
          begin
            rdata[`ANPD_EXP_LPNEG] <= lpNeg_ff;
            rdata[`ANPD_EXP_PDF] <= pdFault_ff;
          end
          `ANPD_QPS_ADDR:
          begin
            rdata[`ANPD_QPS_DONE] <= done_ff;
            rdata[`ANPD_QPS_NOSIG] <= noSig_ff;
          end
          default: rresp <= `ANPD_RESP_SLVERR;
        endcase
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end
endmodule

/* testbench/anpd_partner.sv */
// anpd_partner.sv: far end of the cable, as line indications
// assumes: mode and word driven by the bench just after mclk edges
`timescale 1ns/1ps
module anpd_partner (
  input wire logic mclk,
  input wire logic [2:0] mode,
  input wire logic [15:0] word,
  output logic flpRx,
  output logic nlpRx,
  output logic idleRx,
  output logic wordStb,
  output logic [15:0] wordRx
);
  logic [3:0] dly = 4'h0;
  // partner negotiates only in mode 1
  assign flpRx = (mode == 3'h1);
  assign nlpRx = (mode == 3'h2) || (mode == 3'h4);
  assign idleRx = (mode == 3'h3) || (mode == 3'h4);
  // bursts carry the partner abilities
  // outside a burst the word toggles so stale data never looks valid
  assign wordRx = flpRx ? word : (~word ^ {16{mclk}});
  assign wordStb = (dly == 4'h8);
  always_ff @(posedge mclk)
  begin
    if (!flpRx)
      dly <= 4'h0;
    else if (dly != 4'h8)
      dly <= dly + 4'h1;
  end
endmodule

/* testbench/anpd_arbiter_asserts.sv */
// anpd_arbiter_asserts.sv: port checks on the arbiter
// assumes: bound onto anpd_arbiter, sees its ports only
`timescale 1ns/1ps
module anpd_arbiter_asserts #(
  parameter int WAIT_CYCLES = 4096
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic flpRx,
  input wire logic nlpRx,
  input wire logic idleRx,
  input wire logic sendFlp,
  input wire anpd_pkg::anpd_tech_t techEn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic bvalid,
  input wire logic rvalid
);
  // margin covers synchronizer and arbitration latency
  localparam int SETTLE = WAIT_CYCLES + 32;
  logic [15:0] cnt_ff;
  logic [2:0] lineQ_ff;
  logic [2:0] line;
  assign line = {flpRx, nlpRx, idleRx};
  // cycles with a steady line since bursts began, any write restarts it
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff <= 16'h0000;
      lineQ_ff <= 3'h0;
    end
    else
    begin
      lineQ_ff <= line;
      if (line != lineQ_ff || (awvalid && awready))
        cnt_ff <= 16'h0000;
      else if ((sendFlp || cnt_ff != 16'h0000) && cnt_ff != 16'hFFFF)
        cnt_ff <= cnt_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  tech_onehot_a: assert property ($onehot0(techEn))
    else $error("several technologies enabled");
  send_quiet_a: assert property (sendFlp |-> techEn == 4'h0)
    else $error("technology enabled while sending bursts");
  nlp_select_a: assert property (cnt_ff == SETTLE && line == 3'b010 |-> techEn == 4'h1)
    else $error("link pulses did not select 10 half");
  idle_select_a: assert property (cnt_ff == SETTLE && line == 3'b001 |-> techEn == 4'h4)
    else $error("idles did not select 100 half");
  multi_fault_a: assert property (cnt_ff == SETTLE && line == 3'b011 |-> techEn == 4'h0)
    else $error("technology enabled on mixed indications");
  no_signal_a: assert property (cnt_ff == SETTLE && line == 3'b000 |-> techEn == 4'h0)
    else $error("technology enabled with no partner");
  reset_idle_a: assert property ($rose(nrst) |-> techEn == 4'h0 && !bvalid && !rvalid)
    else $error("not idle after reset");
  b_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  r_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
endmodule
bind anpd_arbiter anpd_arbiter_asserts #(.WAIT_CYCLES(WAIT_CYCLES)) anpd_arbiter_asserts_i (
  .mclk(mclk), .nrst(nrst), .flpRx(flpRx), .nlpRx(nlpRx), .idleRx(idleRx),
  .sendFlp(sendFlp), .techEn(techEn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .arvalid(arvalid), .arready(arready),
  .bvalid(bvalid), .rvalid(rvalid));

/* testbench/anpd_arbiter_tb.sv */
// anpd_arbiter_tb.sv: self-checking bench for the arbiter
// assumes: partner model on the line side, bench as bus master
`timescale 1ns/1ps
`include "anpd_map.svh"
module anpd_arbiter_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [15:0] word = 16'h0000;
  logic flpRx, nlpRx, idleRx, wordStb, sendFlp;
  logic [15:0] wordRx, flpWord;
  anpd_pkg::anpd_tech_t techEn;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs, bs;
  int n_fail = 0;
  int n_checks = 0;
  anpd_arbiter #(.WAIT_CYCLES(16)) anpd_arbiter_i (.mclk(mclk), .nrst(nrst),
    .flpRx(flpRx), .nlpRx(nlpRx), .idleRx(idleRx), .wordStb(wordStb), .wordRx(wordRx),
    .sendFlp(sendFlp), .flpWord(flpWord), .techEn(techEn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  anpd_partner anpd_partner_i (.mclk(mclk), .mode(mode), .word(word), .flpRx(flpRx),
    .nlpRx(nlpRx), .idleRx(idleRx), .wordStb(wordStb), .wordRx(wordRx));
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic results();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axWr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge mclk);
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge mclk);
      if (aw && awready)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axRd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // line quiet during restart so a fresh word strobe follows
  task automatic restart(input logic [2:0] m);
    @(posedge mclk);
    mode <= 3'h0;
    axWr(`ANPD_CTRL_ADDR, 32'h00001200);
    @(posedge mclk);
    mode <= m;
  endtask
  task automatic waitTech();
    int n;
    n = 0;
    // the selection from before a restart still stands in this time step
    @(posedge mclk);
    while (techEn === 4'h0 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic t_reset();
    axRd(`ANPD_CTRL_ADDR);
    chk(rd, 32'h00001000);
    axRd(`ANPD_ADV_ADDR);
    chk(rd, 32'h000001E1);
    chk(32'(rs), 32'(`ANPD_RESP_OKAY));
    chk(32'(flpWord), 32'h000001E1);
    axRd(8'h80);
    chk(32'(rs), 32'(`ANPD_RESP_SLVERR));
    axWr(8'h80, 32'h00000000);
    chk(32'(bs), 32'(`ANPD_RESP_SLVERR));
  endtask
  task automatic t_nego();
    logic [15:0] adv [3] = '{16'h01E1, 16'h00A1, 16'h0061};
    logic [15:0] lp [3] = '{16'h01E1, 16'h01E1, 16'h0061};
    logic [3:0] tech [3] = '{4'h8, 4'h4, 4'h2};
    for (int i = 0; i < 3; i++)
    begin
      axWr(`ANPD_ADV_ADDR, 32'(adv[i]));
      chk(32'(bs), 32'(`ANPD_RESP_OKAY));
      word <= lp[i];
      restart(3'h1);
      waitTech();
      chk(32'(techEn), 32'(tech[i]));
      chk(32'(flpWord), 32'(adv[i]));
      axRd(`ANPD_LPA_ADDR);
      chk(rd, 32'(lp[i]));
      axRd(`ANPD_EXP_ADDR);
      chk(rd & 32'h1, 32'h1);
      axRd(`ANPD_STAT_ADDR);
      chk(rd & 32'h20, 32'h20);
      axRd(`ANPD_QPS_ADDR);
      chk(rd & 32'h10, 32'h10);
    end
  endtask
  task automatic t_parallel();
    logic [2:0] m [2] = '{3'h2, 3'h3};
    logic [3:0] tech [2] = '{4'h1, 4'h4};
    logic [31:0] bit5 [2] = '{32'h20, 32'h80};
    axWr(`ANPD_ADV_ADDR, 32'h000001E1);
    for (int i = 0; i < 2; i++)
    begin
      restart(m[i]);
      waitTech();
      chk(32'(techEn), 32'(tech[i]));
      axRd(`ANPD_LPA_ADDR);
      chk(rd & bit5[i], bit5[i]);
      axRd(`ANPD_EXP_ADDR);
      chk(rd & 32'h1, 32'h0);
      axRd(`ANPD_STAT_ADDR);
      chk(rd & 32'h20, 32'h20);
    end
  endtask
  task automatic t_fault();
    restart(3'h4);
    waitTech();
    chk(32'(techEn), 32'h0);
    axRd(`ANPD_EXP_ADDR);
    chk(rd & 32'h10, 32'h10);
  endtask
  task automatic t_nosig();
    restart(3'h0);
    axRd(`ANPD_CTRL_ADDR);
    chk(rd & 32'h200, 32'h0);
    waitTech();
    chk(32'(techEn), 32'h0);
    axRd(`ANPD_QPS_ADDR);
    chk(rd & 32'h8, 32'h8);
  endtask
  task automatic t_toggle();
    int n;
    restart(3'h2);
    waitTech();
    chk(32'(techEn), 32'h1);
    axWr(`ANPD_CTRL_ADDR, 32'h00000000);
    axWr(`ANPD_CTRL_ADDR, 32'h00001000);
    n = 0;
    while (sendFlp !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      n++;
    end
    chk(32'(sendFlp), 32'h1);
    waitTech();
    chk(32'(techEn), 32'h1);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_nego();
    t_parallel();
    t_fault();
    t_nosig();
    t_toggle();
    results();
  end
  // whole run is under two thousand cycles, this is ample
  initial
  begin
    #500000;
    n_fail++;
    results();
  end
endmodule
